// *** core/pfc_pkg.sv ***
/*
 Shared constants for the fragment header checker: register offsets,
 field positions, reset values and fragment number codes.
 Assumes 32-bit APB data and byte addresses.
*/
package pfc_pkg;
   localparam int          INFO_W       = 21;
   localparam int          CKS_W        = 12;
   localparam int          ACC_W        = 16;
   localparam int          MNUM_W       = 6;
   // Register byte offsets
   localparam logic [11:0] OFS_CTRL     = 12'h000;
   localparam logic [11:0] OFS_STATUS   = 12'h004;
   localparam logic [11:0] OFS_MISS     = 12'h008;
   localparam logic [11:0] OFS_LAST     = 12'h00c;
   // Control fields
   localparam int          CTRL_EN_BIT  = 0;
   localparam int          CTRL_WRAP_LO = 8;
   localparam logic        CTRL_EN_RST  = 1'b1;
   localparam logic [5:0]  WRAP_RST     = 6'h3f;
   // Status fields
   localparam int          ST_FRAG_ERR  = 0;
   localparam int          ST_SEQ_ERR   = 1;
   localparam int          ST_MISSED    = 2;
   localparam int          ST_OPEN      = 3;
   localparam int          ST_DROP      = 4;
   localparam int          ST_RETR      = 5;
   // Miss register fields
   localparam int          MISS_ADDR_LO = 8;
   // First-word field positions
   localparam int          FW_CKS_LO    = 0;
   localparam int          FW_CONT      = 12;
   localparam int          FW_FRAG_LO   = 13;
   localparam int          FW_NUM_LO    = 15;
   // Second-word flag positions of an initial fragment
   localparam int          SW_RETR      = 0;
   localparam int          SW_DROP      = 1;
   localparam int          SW_HDR       = 3;
   // Last-fragment register fields
   localparam int          LF_FRAG_LO   = 6;
   localparam int          LF_CONT      = 8;
   localparam int          LF_OK        = 9;
   localparam int          LF_RETR      = 10;
   localparam int          LF_DROP      = 11;
   localparam int          LF_HDR       = 12;
   localparam int          LF_SUM_LO    = 16;
   // Fragment numbers and message number reset
   localparam logic [1:0]  FRAG_INIT    = 2'b11;
   localparam logic [1:0]  FRAG_FIRST   = 2'b00;
   localparam logic [5:0]  MNUM_RST     = 6'h00;
endpackage

// *** core/pfc_sum_if.sv ***
/*
 Carrier between the checker and its checksum accumulator.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface pfc_sum_if;
   logic                          valid;
   logic                          first;
   logic [pfc_pkg::INFO_W-1:0]    word;
   logic [pfc_pkg::ACC_W-1:0]     total;

   modport ctl (output valid, output first, output word, input total);
   modport acc (input valid, input first, input word, output total);
endinterface

// *** core/pfc_fold_sum.sv ***
/*
 Running fragment sum over three addends per code word.
 Assumes words arrive in order with first marking a fragment's first word.
*/
`timescale 1ns/1ps
module pfc_fold_sum
   import pfc_pkg::*;
(
   input  wire logic  mclk,
   input  wire logic  rst,
   pfc_sum_if.acc     sb
);
   logic [INFO_W-1:0] w_eff;
   logic [ACC_W-1:0]  base;
   logic [ACC_W-1:0]  sum_q;

   // Checksum field counts as zero in the first word
   always_comb begin
      w_eff = sb.word;
      if (sb.first) begin
         w_eff[FW_CKS_LO +: CKS_W] = '0;
      end
   end

   assign base = sb.first ? '0 : sum_q;
   // Three addends: bits 0-7, 8-15, 16-20
   assign sb.total = base + ACC_W'(w_eff[7:0]) + ACC_W'(w_eff[15:8])
                     + ACC_W'(w_eff[20:16]);

   // Every word of the fragment is added
   always_ff @(posedge mclk) begin
      if (rst) begin
         sum_q <= '0;
      end else if (sb.valid) begin
         sum_q <= sb.total;
      end
   end
endmodule // pfc_fold_sum

// *** core/pfc_header_checker.sv ***
/*
 Fragment header checker: checksum, continuation, fragment numbering,
 per-address message numbering, retrieval and mail-drop flags, APB registers.
 Assumes the receive path delivers one fragment's words in order, first and
 last marked, with the paging address index steady during the fragment.
*/
`timescale 1ns/1ps
module pfc_header_checker
   import pfc_pkg::*;
#(
   parameter int NUM_ADDR = 4,
   parameter int ADDR_W   = 2
)(
   input  wire logic                mclk,
   input  wire logic                rst,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                wd_valid,
   input  wire logic                wd_first,
   input  wire logic                wd_last,
   input  wire logic [INFO_W-1:0]   wd_data,
   input  wire logic [ADDR_W-1:0]   wd_addr,
   output logic                     frag_done,
   output logic                     frag_ok,
   output logic                     msg_done,
   output logic                     store_drop,
   output logic                     drop_restart,
   output logic                     missed_pulse,
   output logic      [ADDR_W-1:0]   missed_addr,
   output logic      [MNUM_W-1:0]   missed_num
);
   import pfc_pkg::*;
   pfc_sum_if sb ();
   logic                en_q;
   logic [MNUM_W-1:0]   wrap_q;
   logic                frag_err_q;
   logic                seq_err_q;
   logic                missed_q;
   logic [ADDR_W-1:0]   miss_addr_q;
   logic [MNUM_W-1:0]   miss_num_q;
   logic [31:0]         last_q;
   logic [CKS_W-1:0]    k_q;
   logic                c_q;
   logic [1:0]          f_q;
   logic [MNUM_W-1:0]   n_q;
   logic                second_q;
   logic                r_q;
   logic                m_q;
   logic                h_q;
   logic                open_q;
   logic [ADDR_W-1:0]   open_addr_q;
   logic [MNUM_W-1:0]   open_num_q;
   logic [1:0]          open_next_q;
   logic                open_r_q;
   logic                open_m_q;
   logic                open_h_q;
   logic [MNUM_W-1:0]   exp_q [NUM_ADDR];
   logic                frag_done_q;
   logic                frag_ok_q;
   logic                msg_done_q;
   logic                drop_q;
   logic                drop_restart_q;
   logic                missed_pulse_q;
   logic                wr_acc;
   logic                rd_acc;
   logic                mapped;
   logic                end_evt;
   logic [CKS_W-1:0]    k_cur;
   logic                c_cur;
   logic [1:0]          f_cur;
   logic [MNUM_W-1:0]   n_cur;
   logic                r_cur;
   logic                m_cur;
   logic                h_cur;
   logic [CKS_W-1:0]    cks_calc;
   logic                cks_ok;
   logic                joined;
   logic                seq_bad;
   logic                start_new;
   logic                miss_evt;
   logic [MNUM_W-1:0]   exp_cur;
   logic                clr_frag;
   logic                clr_seq;
   logic                clr_miss;
   // Modulo-3 successor of a fragment number, never back to 11
   function automatic logic [1:0] frag_succ(input logic [1:0] f);
      return (f == 2'b10 || f == FRAG_INIT) ? FRAG_FIRST : f + 2'b01;
   endfunction
   // Next message number with a host-set wrap point
   function automatic logic [MNUM_W-1:0] num_succ(input logic [MNUM_W-1:0] n,
                                                  input logic [MNUM_W-1:0] w);
      return (n >= w) ? MNUM_RST : n + 6'h01;
   endfunction
   assign sb.valid = wd_valid;
   assign sb.first = wd_first;
   assign sb.word  = wd_data;

   pfc_fold_sum u_sum (
      .mclk (mclk),
      .rst  (rst),
      .sb   (sb)
   );

   // First-word fields, taken live on the first word
   assign k_cur = wd_first ? wd_data[FW_CKS_LO +: CKS_W] : k_q;
   assign c_cur = wd_first ? wd_data[FW_CONT] : c_q;
   assign f_cur = wd_first ? wd_data[FW_FRAG_LO +: 2] : f_q;
   assign n_cur = wd_first ? wd_data[FW_NUM_LO +: MNUM_W] : n_q;

   // Flags of an initial fragment; later fragments reuse the held ones
   always_comb begin
      r_cur = r_q;
      m_cur = m_q;
      h_cur = h_q;
      if (f_cur != FRAG_INIT) begin
         r_cur = open_r_q;
         m_cur = open_m_q;
         h_cur = open_h_q;
      end else if (wd_first) begin
         r_cur = 1'b0;
         m_cur = 1'b0;
         h_cur = 1'b0;
      end else if (second_q) begin
         r_cur = wd_data[SW_RETR];
         m_cur = wd_data[SW_DROP];
         h_cur = wd_data[SW_HDR];
      end
   end

   assign end_evt  = wd_valid && wd_last && en_q;
   assign cks_calc = ~sb.total[CKS_W-1:0];
   assign cks_ok   = (cks_calc == k_cur);
   assign joined   = open_q && (open_addr_q == wd_addr) && (open_num_q == n_cur);
   assign exp_cur  = exp_q[wd_addr];

   always_comb begin
      seq_bad   = 1'b0;
      start_new = 1'b0;
      if (joined) begin
         seq_bad = (f_cur != open_next_q);
      end else if (f_cur != FRAG_INIT) begin
         seq_bad = 1'b1;
      end else begin
         start_new = 1'b1;
      end
   end

   // Gap only counts for retrieval messages
   assign miss_evt = end_evt && cks_ok && start_new && r_cur
                     && (n_cur != exp_cur);

   // Capture first-word fields and initial-fragment flags
   always_ff @(posedge mclk) begin
      if (rst) begin
         k_q      <= '0;
         c_q      <= 1'b0;
         f_q      <= FRAG_INIT;
         n_q      <= MNUM_RST;
         second_q <= 1'b0;
         r_q      <= 1'b0;
         m_q      <= 1'b0;
         h_q      <= 1'b0;
      end else if (wd_valid) begin
         k_q      <= k_cur;
         c_q      <= c_cur;
         f_q      <= f_cur;
         n_q      <= n_cur;
         second_q <= wd_first;
         r_q      <= r_cur;
         m_q      <= m_cur;
         h_q      <= h_cur;
      end
   end

   // Open message tracking
   always_ff @(posedge mclk) begin
      if (rst) begin
         open_q      <= 1'b0;
         open_addr_q <= '0;
         open_num_q  <= MNUM_RST;
         open_next_q <= FRAG_FIRST;
         open_r_q    <= 1'b0;
         open_m_q    <= 1'b0;
         open_h_q    <= 1'b0;
      end else if (end_evt && cks_ok) begin
         if (seq_bad) begin
            open_q <= 1'b0;
         end else begin
            open_q      <= c_cur;
            open_addr_q <= wd_addr;
            open_num_q  <= n_cur;
            open_next_q <= frag_succ(f_cur);
            open_r_q    <= r_cur;
            open_m_q    <= m_cur;
            open_h_q    <= h_cur;
         end
      end
   end

   // Expected message number per address
   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < NUM_ADDR; i++) begin
            exp_q[i] <= MNUM_RST;
         end
      end else if (end_evt && cks_ok && start_new && r_cur) begin
         // Header keeps its number for the transparent message that follows
         exp_q[wd_addr] <= h_cur ? n_cur : num_succ(n_cur, wrap_q);
      end
   end

   // Event outputs
   always_ff @(posedge mclk) begin
      if (rst) begin
         frag_done_q    <= 1'b0;
         frag_ok_q      <= 1'b0;
         msg_done_q     <= 1'b0;
         drop_q         <= 1'b0;
         drop_restart_q <= 1'b0;
         missed_pulse_q <= 1'b0;
         last_q         <= '0;
      end else begin
         frag_done_q    <= end_evt;
         missed_pulse_q <= miss_evt;
         msg_done_q     <= end_evt && cks_ok && !seq_bad && !c_cur;
         drop_restart_q <= end_evt && cks_ok && start_new && m_cur;
         if (end_evt) begin
            frag_ok_q <= cks_ok && !seq_bad;
            drop_q    <= m_cur;
            last_q    <= {4'h0, cks_calc, 3'h0, h_cur, m_cur, r_cur, cks_ok,
                          c_cur, f_cur, n_cur};
         end
      end
   end

   // APB access decode
   assign wr_acc   = psel && penable && pwrite;
   assign rd_acc   = psel && !pwrite;
   assign mapped   = (paddr == OFS_CTRL) || (paddr == OFS_STATUS)
                     || (paddr == OFS_MISS) || (paddr == OFS_LAST);
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !mapped;
   assign clr_frag = wr_acc && (paddr == OFS_STATUS) && pwdata[ST_FRAG_ERR];
   assign clr_seq  = wr_acc && (paddr == OFS_STATUS) && pwdata[ST_SEQ_ERR];
   assign clr_miss = wr_acc && (paddr == OFS_STATUS) && pwdata[ST_MISSED];

   // Control register
   always_ff @(posedge mclk) begin
      if (rst) begin
         en_q   <= CTRL_EN_RST;
         wrap_q <= WRAP_RST;
      end else if (wr_acc && paddr == OFS_CTRL) begin
         en_q   <= pwdata[CTRL_EN_BIT];
         wrap_q <= pwdata[CTRL_WRAP_LO +: MNUM_W];
      end
   end

   // Sticky status, set wins over clear
   always_ff @(posedge mclk) begin
      if (rst) begin
         frag_err_q <= 1'b0;
         seq_err_q  <= 1'b0;
      end else begin
         frag_err_q <= (end_evt && !cks_ok) || (frag_err_q && !clr_frag);
         seq_err_q  <= (end_evt && cks_ok && seq_bad) || (seq_err_q && !clr_seq);
      end
   end

   // Missed report held until acknowledged
   always_ff @(posedge mclk) begin
      if (rst) begin
         missed_q    <= 1'b0;
         miss_addr_q <= '0;
         miss_num_q  <= MNUM_RST;
      end else begin
         missed_q <= miss_evt || (missed_q && !clr_miss);
         if (miss_evt && (!missed_q || clr_miss)) begin
            miss_addr_q <= wd_addr;
            miss_num_q  <= exp_cur;
         end
      end
   end

   // Read data
   always_ff @(posedge mclk) begin
      if (rst) begin
         prdata <= '0;
      end else if (rd_acc && !penable) begin
         unique case (paddr)
            OFS_CTRL:   prdata <= 32'({wrap_q, 7'h00, en_q});
            OFS_STATUS: prdata <= 32'({open_r_q & open_q, open_m_q & open_q, open_q,
                                       missed_q, seq_err_q, frag_err_q});
            OFS_MISS:   prdata <= 32'({8'(miss_addr_q), 2'b00, miss_num_q});
            OFS_LAST:   prdata <= last_q;
            default:    prdata <= '0;
         endcase
      end
   end

   assign frag_done    = frag_done_q;
   assign frag_ok      = frag_ok_q;
   assign msg_done     = msg_done_q;
   assign store_drop   = drop_q;
   assign drop_restart = drop_restart_q;
   assign missed_pulse = missed_pulse_q;
   assign missed_addr  = miss_addr_q;
   assign missed_num   = miss_num_q;
endmodule // pfc_header_checker

// *** dv/pfc_header_checker_monitor.sv ***
/*
 Checker of port relations of the fragment header checker.
 Assumes one clock mclk and synchronous active-high rst.
*/
`timescale 1ns/1ps
module pfc_header_checker_monitor
   import pfc_pkg::*;
#(
   parameter int NUM_ADDR = 4,
   parameter int ADDR_W   = 2
)(
   input wire logic              mclk,
   input wire logic              rst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [11:0]       paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              wd_valid,
   input wire logic              wd_first,
   input wire logic              wd_last,
   input wire logic [INFO_W-1:0] wd_data,
   input wire logic [ADDR_W-1:0] wd_addr,
   input wire logic              frag_done,
   input wire logic              frag_ok,
   input wire logic              msg_done,
   input wire logic              store_drop,
   input wire logic              drop_restart,
   input wire logic              missed_pulse,
   input wire logic [ADDR_W-1:0] missed_addr,
   input wire logic [MNUM_W-1:0] missed_num
);
   logic unmapped;
   // Any address off the four word offsets, misaligned ones too
   assign unmapped = (paddr != OFS_CTRL) && (paddr != OFS_STATUS) && (paddr != OFS_MISS)
                     && (paddr != OFS_LAST);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_word_end;
      wd_valid && wd_last;
   endsequence
   chk_zero_wait: assert property (s_access |-> pready)
      else $error("access without ready");
   chk_unmapped_err: assert property (s_access ##0 unmapped |-> pslverr)
      else $error("unmapped access without error");
   chk_err_cause: assert property (pslverr |-> psel && penable && unmapped)
      else $error("error response without cause");
   chk_done_after_word: assert property (frag_done |-> $past(wd_valid && wd_last))
      else $error("fragment end without last word");
   chk_msg_closes: assert property (msg_done |-> frag_done && frag_ok)
      else $error("message closed without good fragment");
   chk_miss_on_good: assert property (missed_pulse |-> frag_done && frag_ok)
      else $error("missed report without good fragment");
   chk_drop_restart: assert property (drop_restart |-> frag_done && frag_ok && store_drop)
      else $error("drop area restart without drop flag");
   chk_ok_level: assert property (!frag_done |-> $stable(frag_ok))
      else $error("fragment status moved between ends");
   chk_drop_held: assert property (!frag_done |-> $stable(store_drop))
      else $error("drop flag moved between ends");
   chk_miss_latched: assert property (!missed_pulse |-> $stable({missed_addr, missed_num}))
      else $error("missed report changed without pulse");
   chk_end_seen: cover property (s_word_end ##1 frag_done);
endmodule // pfc_header_checker_monitor

bind pfc_header_checker pfc_header_checker_monitor #(.NUM_ADDR(NUM_ADDR), .ADDR_W(ADDR_W)) u_mon (
   .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .wd_valid(wd_valid), .wd_first(wd_first), .wd_last(wd_last), .wd_data(wd_data),
   .wd_addr(wd_addr), .frag_done(frag_done), .frag_ok(frag_ok), .msg_done(msg_done),
   .store_drop(store_drop), .drop_restart(drop_restart), .missed_pulse(missed_pulse),
   .missed_addr(missed_addr), .missed_num(missed_num)
);

// *** dv/pfc_word_feed.sv ***
/*
 Receive path model: sends one fragment of three code words.
 Assumes the caller waits for the task to return between fragments.
*/
`timescale 1ns/1ps
module pfc_word_feed
   import pfc_pkg::*;
#(
   parameter int ADDR_W = 2
)(
   input  wire logic              mclk,
   output logic                   wd_valid,
   output logic                   wd_first,
   output logic                   wd_last,
   output logic [INFO_W-1:0]      wd_data,
   output logic [ADDR_W-1:0]      wd_addr,
   output logic [CKS_W-1:0]       last_k
);
   initial begin
      wd_valid = 1'b0;
      wd_first = 1'b0;
      wd_last  = 1'b0;
      wd_data  = 21'h0;
      wd_addr  = '0;
      last_k   = 12'h0;
   end
   task automatic send(input logic [ADDR_W-1:0] a, input logic c, input logic [1:0] f,
                       input logic [5:0] n, input logic r, m, h, bad);
      logic [INFO_W-1:0] w [3];
      logic [ACC_W-1:0]  s;
      w[0] = {n, f, c, 12'h000};
      w[1] = 21'h15a30;
      if (f == FRAG_INIT) begin
         w[1][SW_RETR] = r;
         w[1][SW_DROP] = m;
         w[1][SW_HDR]  = h;
      end
      w[2] = 21'h0f0f1;
      s = 16'h0;
      for (int i = 0; i < 3; i++) s += w[i][7:0] + w[i][15:8] + w[i][20:16];
      last_k = ~s[11:0] ^ {11'h0, bad};
      w[0][11:0] = last_k;
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk);
         wd_valid <= 1'b1;
         wd_first <= (i == 0);
         wd_last  <= (i == 2);
         wd_data  <= w[i];
         wd_addr  <= a;
      end
      @(posedge mclk);
      wd_valid <= 1'b0;
      wd_first <= 1'b0;
      wd_last  <= 1'b0;
      wd_data  <= ~w[2];
      wd_addr  <= ~a;
   endtask
endmodule // pfc_word_feed

// *** dv/pfc_header_checker_bench.sv ***
/*
 Self-checking bench of the fragment header checker.
 Assumes the checker is bound by its own file and APB answers at once.
*/
`timescale 1ns/1ps
module pfc_header_checker_bench;
   import pfc_pkg::*;
   logic              mclk, rst, psel, penable, pwrite, pready, pslverr, rde;
   logic [11:0]       paddr, last_k;
   logic [31:0]       pwdata, prdata, rdv;
   logic              wd_valid, wd_first, wd_last, frag_done, frag_ok, msg_done;
   logic              store_drop, drop_restart, missed_pulse;
   logic [INFO_W-1:0] wd_data;
   logic [1:0]        wd_addr, missed_addr;
   logic [MNUM_W-1:0] missed_num;
   int                err_total = 0;
   int                total_checks = 0;

   pfc_header_checker #(.NUM_ADDR(4), .ADDR_W(2)) u_dut (
      .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wd_valid(wd_valid), .wd_first(wd_first), .wd_last(wd_last),
      .wd_data(wd_data), .wd_addr(wd_addr), .frag_done(frag_done), .frag_ok(frag_ok),
      .msg_done(msg_done), .store_drop(store_drop), .drop_restart(drop_restart),
      .missed_pulse(missed_pulse), .missed_addr(missed_addr), .missed_num(missed_num));
   pfc_word_feed #(.ADDR_W(2)) u_src (
      .mclk(mclk), .wd_valid(wd_valid), .wd_first(wd_first), .wd_last(wd_last),
      .wd_data(wd_data), .wd_addr(wd_addr), .last_k(last_k));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (n >= 64) chk("pready", 32'h1, 32'h0);
      rdv = prdata;
      rde = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rdv);
   endtask
   task automatic fr(input logic [1:0] a, input logic c, input logic [1:0] f,
                     input logic [5:0] n, input logic r, m, h, bad, input logic [4:0] e);
      u_src.send(a, c, f, n, r, m, h, bad);
      #1;
      chk("events", e, {frag_done, frag_ok, msg_done, missed_pulse, drop_restart});
   endtask

   task automatic t_regs;
      rd(OFS_CTRL, 32'h3f01);
      rd(OFS_STATUS, 32'h0);
      wr(12'h010, 32'hffffffff);
      chk("pslverr", 32'h1, rde);
      rd(12'h010, 32'h0);
      chk("pslverr", 32'h1, rde);
      rd(12'h002, 32'h0);
      chk("pslverr", 32'h1, rde);
      $display("test regs done");
   endtask
   task automatic t_checksum;
      fr(2'h0, 1'b0, FRAG_INIT, 6'h0, 1'b1, 1'b0, 1'b0, 1'b0, 5'b11100);
      rd(OFS_LAST, {4'h0, last_k, 16'h06c0});
      fr(2'h0, 1'b0, FRAG_INIT, 6'h1, 1'b1, 1'b0, 1'b0, 1'b1, 5'b10000);
      rd(OFS_STATUS, 32'h1);
      wr(OFS_STATUS, 32'h1);
      rd(OFS_STATUS, 32'h0);
      $display("test checksum done");
   endtask
   task automatic t_fragments;
      logic [1:0] fv [5] = '{2'b00, 2'b01, 2'b10, 2'b00, 2'b01};
      fr(2'h1, 1'b1, FRAG_INIT, 6'h0, 1'b1, 1'b0, 1'b0, 1'b0, 5'b11000);
      rd(OFS_STATUS, 32'h28);
      for (int i = 0; i < 5; i++) begin
         fr(2'h1, i < 4, fv[i], 6'h0, 1'b0, 1'b0, 1'b0, 1'b0, i < 4 ? 5'b11000 : 5'b11100);
      end
      rd(OFS_STATUS, 32'h0);
      $display("test fragments done");
   endtask
   task automatic t_sequence;
      fr(2'h1, 1'b1, FRAG_INIT, 6'h1, 1'b1, 1'b0, 1'b0, 1'b0, 5'b11000);
      fr(2'h1, 1'b1, 2'b01, 6'h1, 1'b0, 1'b0, 1'b0, 1'b0, 5'b10000);
      rd(OFS_STATUS, 32'h2);
      fr(2'h1, 1'b1, FRAG_INIT, 6'h2, 1'b1, 1'b0, 1'b0, 1'b0, 5'b11000);
      fr(2'h2, 1'b1, FRAG_FIRST, 6'h2, 1'b0, 1'b0, 1'b0, 1'b0, 5'b10000);
      fr(2'h1, 1'b1, FRAG_INIT, 6'h3, 1'b1, 1'b0, 1'b0, 1'b0, 5'b11000);
      fr(2'h1, 1'b1, FRAG_FIRST, 6'h4, 1'b0, 1'b0, 1'b0, 1'b0, 5'b10000);
      wr(OFS_STATUS, 32'h2);
      rd(OFS_STATUS, 32'h0);
      $display("test sequence done");
   endtask
   task automatic t_missed;
      fr(2'h2, 1'b0, FRAG_INIT, 6'h3, 1'b1, 1'b0, 1'b0, 1'b0, 5'b11110);
      chk("missed_addr", 32'h2, missed_addr);
      chk("missed_num", 32'h0, missed_num);
      rd(OFS_MISS, 32'h200);
      fr(2'h2, 1'b0, FRAG_INIT, 6'h4, 1'b1, 1'b0, 1'b0, 1'b0, 5'b11100);
      fr(2'h2, 1'b0, FRAG_INIT, 6'h9, 1'b0, 1'b0, 1'b0, 1'b0, 5'b11100);
      fr(2'h2, 1'b0, FRAG_INIT, 6'h5, 1'b1, 1'b0, 1'b0, 1'b0, 5'b11100);
      fr(2'h3, 1'b0, FRAG_INIT, 6'h0, 1'b1, 1'b0, 1'b0, 1'b0, 5'b11100);
      rd(OFS_STATUS, 32'h4);
      wr(OFS_STATUS, 32'h4);
      rd(OFS_STATUS, 32'h0);
      fr(2'h0, 1'b0, FRAG_INIT, 6'h1, 1'b1, 1'b0, 1'b1, 1'b0, 5'b11100);
      fr(2'h0, 1'b0, FRAG_INIT, 6'h1, 1'b1, 1'b0, 1'b0, 1'b0, 5'b11100);
      fr(2'h0, 1'b0, FRAG_INIT, 6'h2, 1'b1, 1'b0, 1'b0, 1'b0, 5'b11100);
      $display("test missed done");
   endtask
   task automatic t_wrap;
      wr(OFS_CTRL, 32'h0201);
      rd(OFS_CTRL, 32'h0201);
      fr(2'h3, 1'b0, FRAG_INIT, 6'h1, 1'b1, 1'b0, 1'b0, 1'b0, 5'b11100);
      fr(2'h3, 1'b0, FRAG_INIT, 6'h2, 1'b1, 1'b0, 1'b0, 1'b0, 5'b11100);
      fr(2'h3, 1'b0, FRAG_INIT, 6'h0, 1'b1, 1'b0, 1'b0, 1'b0, 5'b11100);
      wr(OFS_CTRL, 32'h0200);
      fr(2'h3, 1'b0, FRAG_INIT, 6'h9, 1'b1, 1'b0, 1'b0, 1'b0, 5'b01000);
      wr(OFS_CTRL, 32'h3f01);
      $display("test wrap done");
   endtask
   task automatic t_drop;
      fr(2'h0, 1'b1, FRAG_INIT, 6'h7, 1'b0, 1'b1, 1'b0, 1'b0, 5'b11001);
      rd(OFS_STATUS, 32'h18);
      fr(2'h0, 1'b0, FRAG_FIRST, 6'h7, 1'b0, 1'b0, 1'b0, 1'b0, 5'b11100);
      chk("store_drop", 32'h1, store_drop);
      fr(2'h0, 1'b0, FRAG_INIT, 6'h8, 1'b0, 1'b0, 1'b0, 1'b0, 5'b11100);
      chk("store_drop", 32'h0, store_drop);
      $display("test drop done");
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #200000;
      err_total++;
      end_of_test;
   end
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      t_regs;
      t_checksum;
      t_fragments;
      t_sequence;
      t_missed;
      t_wrap;
      t_drop;
      end_of_test;
   end
endmodule // pfc_header_checker_bench
